// [hdl/scs_params.svh]
// constants of the conversion sequencer: widths, codes and timing counts
// assumes a 10 MHz conversion clock and a host-driven shift clock
// Notes on behaviour
// - conversion starts on select fall after acquisition
// - open ground switches, then ground both arrays
// - sixteen binary-weighted trials, most significant first
// - after last trial, reacquire and form code
// - code belongs to this sample, no latency
// - up to 100 kSPS, power down between
// - sixteen-bit straight binary output code
// - overrange input saturates to all ones
// - underrange input saturates to all zeros
// - acquisition: comparator side grounded, arrays track
// - serial output high impedance while select high
// - fifth shift edge drives low, then MSB first
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
`define SCS_CODE_BITS 16
`define SCS_CLK_MHZ 10
`define SCS_ACQ_TIME_NS 400
`define SCS_ACQ_CYC ((`SCS_ACQ_TIME_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_RATE_KSPS 100
`define SCS_CONV_CYC 18
`define SCS_LOAD_EDGE 5'h04
`define SCS_LAST_EDGE 5'h15
`define SCS_CODE_MID 16'h8000
`define SCS_CODE_FULL 16'hffff
`define SCS_CODE_ZERO 16'h0000
`endif

// [hdl/scs_pkg.sv]
// types shared by the conversion sequencer
// assumes the constants header sits beside it
package scs_pkg;
	// sequencer phases, one-hot
	typedef enum logic [3:0] {
		SCS_ACQ = 4'h1,
		SCS_OPEN = 4'h2,
		SCS_HOLD = 4'h4,
		SCS_TRIAL = 4'h8
	} scs_phase_t;

	// state on the conversion clock
	typedef struct packed {
		logic sel_meta;
		logic sel_sync;
		logic sel_prev;
		scs_phase_t phase;
		logic [3:0] bit_idx;
		logic [15:0] trial;
		logic [15:0] result;
		logic result_valid;
		logic [7:0] acq_cnt;
		logic gnd_closed;
		logic to_input;
		logic to_ground;
		logic powered;
	} scs_core_t;

	// state on the host shift clock
	typedef struct packed {
		logic valid_meta;
		logic valid_sync;
		logic [4:0] edge_cnt;
		logic [15:0] shift;
		logic sdo;
		logic oe;
	} scs_link_t;
endpackage : scs_pkg

// [hdl/scs_sequencer.sv]
// conversion sequencer: switch control, successive approximation and serial readout
// assumes comparator_high is latched by the conversion clock; select and shift clock
// come from the host pins, the shift clock only runs inside a frame
`timescale 1ns/1ps
`include "scs_params.svh"

module scs_sequencer import scs_pkg::*; (
	// conversion clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// host pins
	input wire logic chip_select_n,
	input wire logic host_shift_clock,
	output logic serial_data,
	output logic serial_data_oe,
	// analog front end
	input wire logic comparator_high,
	output logic pos_array_ground_switch,
	output logic neg_array_ground_switch,
	output logic array_to_input,
	output logic array_to_ground,
	output logic [15:0] dac_ref_select,
	output logic converter_powered,
	// parallel result
	output logic [15:0] result_code,
	output logic result_valid
);
	// rounded up to whole cycles, so a slow clock never cuts the sample short
	localparam logic [7:0] ACQ_CYC = 8'(`SCS_ACQ_CYC); // least acquisition, whole cycles

	scs_core_t core; // conversion-clock state
	scs_core_t next_core;
	scs_link_t link; // shift-clock state
	scs_link_t next_link;
	logic sel_fall; // synchronised select falling edge
	logic acq_done; // acquisition long enough
	logic link_rst_n; // frame end clears the link side

	assign sel_fall = core.sel_prev & ~core.sel_sync;
	assign acq_done = (core.acq_cnt >= ACQ_CYC);

	// next state of the conversion side
	always_comb begin
		next_core = core;
		// select pin passes two flops before the conversion side reads it
		next_core.sel_meta = chip_select_n;
		next_core.sel_sync = core.sel_meta;
		next_core.sel_prev = core.sel_sync;
		case (core.phase)
			SCS_ACQ: begin
				// arrays track the input, comparator side grounded
				next_core.gnd_closed = 1'b1;
				next_core.to_input = 1'b1;
				next_core.to_ground = 1'b0;
				next_core.powered = 1'b0;
				// saturates at the limit, so a long idle needs no wrap guard
				if (!acq_done) begin
					next_core.acq_cnt = core.acq_cnt + 8'h01;
				end
				// an early select fall is ignored: sample not yet settled
				if (sel_fall && acq_done) begin
					next_core.phase = SCS_OPEN;
					next_core.gnd_closed = 1'b0;
					next_core.powered = 1'b1;
					next_core.result_valid = 1'b0;
				end
			end
			SCS_OPEN: begin
				// ground switches already open; now swap arrays to ground
				next_core.to_input = 1'b0;
				next_core.to_ground = 1'b1;
				next_core.trial = `SCS_CODE_MID;
				next_core.bit_idx = 4'hf;
				next_core.phase = SCS_HOLD;
			end
			SCS_HOLD: begin
				// one cycle for the comparator to settle on the first trial
				// costs one cycle per conversion, well inside the rate budget
				next_core.phase = SCS_TRIAL;
			end
			SCS_TRIAL: begin
				// decide the tested bit, then try the next one down
				next_core.trial[core.bit_idx] = comparator_high;
				if (core.bit_idx != 4'h0) begin
					next_core.trial[core.bit_idx - 4'h1] = 1'b1;
					next_core.bit_idx = core.bit_idx - 4'h1;
				end else begin
					// last trial: hand over the code and reacquire
					next_core.result = {core.trial[15:1], comparator_high};
					next_core.result_valid = 1'b1;
					next_core.phase = SCS_ACQ;
					next_core.gnd_closed = 1'b1;
					next_core.to_input = 1'b1;
					next_core.to_ground = 1'b0;
					next_core.powered = 1'b0;
					next_core.acq_cnt = 8'h00;
				end
			end
			default: begin
				next_core.phase = SCS_ACQ;
			end
		endcase
	end

	// register the conversion side
	// select flops reset high, the pin's idle level, so no false fall follows reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core <= '{sel_meta: 1'b1, sel_sync: 1'b1, sel_prev: 1'b1, phase: SCS_ACQ,
				gnd_closed: 1'b1, to_input: 1'b1, default: '0};
		end else begin
			core <= next_core;
		end
	end

	assign pos_array_ground_switch = core.gnd_closed;
	assign neg_array_ground_switch = core.gnd_closed;
	assign array_to_input = core.to_input;
	assign array_to_ground = core.to_ground;
	assign dac_ref_select = core.trial;
	assign converter_powered = core.powered;
	assign result_code = core.result;
	assign result_valid = core.result_valid;

	// select high holds the link side cleared, so the stopped clock needs no edge to end
	// a frame cut short by select rising leaves nothing behind for the next one
	assign link_rst_n = rst_n & ~chip_select_n;

	// next state of the readout side, advanced on shift-clock falling edges
	// the result word crosses unsynchronised: it stands still while valid is high
	always_comb begin
		next_link = link;
		next_link.valid_meta = core.result_valid;
		next_link.valid_sync = link.valid_meta;
		// count up to the last edge, then hold so a long frame cannot wrap
		if (link.edge_cnt != `SCS_LAST_EDGE) begin
			next_link.edge_cnt = link.edge_cnt + 5'h01;
		end
		if (link.edge_cnt == `SCS_LOAD_EDGE) begin
			// fifth edge: drive low and take the word, stable while valid
			next_link.oe = 1'b1;
			next_link.sdo = 1'b0;
			next_link.shift = link.valid_sync ? core.result : `SCS_CODE_ZERO;
		end else if (link.oe && link.edge_cnt != `SCS_LAST_EDGE) begin
			// later edges: one bit per edge, most significant first
			next_link.sdo = link.shift[15];
			next_link.shift = {link.shift[14:0], 1'b0};
		end else if (link.edge_cnt == `SCS_LAST_EDGE) begin
			// past the last bit the line rests low until select rises
			next_link.sdo = 1'b0;
		end
	end

	// register the readout side
	always_ff @(negedge host_shift_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	assign serial_data = link.sdo;
	assign serial_data_oe = link.oe;

	// conversion-side checks
	// long runs are split into two runs of eight, walked through the bit index, or spanned by one ##15 or ##17 delay
	AST_GND_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_OPEN) |-> (!core.gnd_closed && core.to_input
		##1 !core.to_input && core.to_ground))
		else $error("arrays moved before ground switches opened");
	AST_START_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_OPEN) |-> ($past(core.phase) == SCS_ACQ && $past(sel_fall)
		&& $past(acq_done)))
		else $error("conversion began without select fall after acquisition");
	AST_SIXTEEN: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_HOLD) |=> (core.phase == SCS_TRIAL && core.bit_idx == 4'hf)
		##15 (core.phase == SCS_TRIAL && core.bit_idx == 4'h0) ##1 (core.phase == SCS_ACQ))
		else $error("trial count is not sixteen");
	// with the sixteen-trial check this pins sixteen back-to-back trials
	AST_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_TRIAL && core.bit_idx != 4'h0) |=>
		(core.phase == SCS_TRIAL && core.bit_idx == $past(core.bit_idx) - 4'h1))
		else $error("trial index did not step down by one");
	AST_DECIDE: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_TRIAL) |=> core.trial[$past(core.bit_idx)] == $past(comparator_high))
		else $error("trial bit does not follow comparator");
	AST_RESULT: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_TRIAL && core.bit_idx == 4'h0) |=> (result_valid
		&& core.result == core.trial && core.phase == SCS_ACQ))
		else $error("result not formed from this conversion");
	AST_TRACK: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_ACQ) |-> (core.gnd_closed && core.to_input && !core.powered))
		else $error("arrays not tracking during acquisition");
	AST_POWER: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_OPEN) |-> (core.powered ##17 core.powered ##1 !core.powered))
		else $error("power window is not eighteen cycles");
	// sixteen decisions checked as two back-to-back runs of eight
	AST_FULL: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_HOLD) ##1 comparator_high[*8] ##1 comparator_high[*8] |=>
		(core.result == `SCS_CODE_FULL))
		else $error("overrange did not give all ones");
	AST_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_HOLD) ##1 (!comparator_high)[*8] ##1 (!comparator_high)[*8]
		|=> (core.result == `SCS_CODE_ZERO))
		else $error("underrange did not give all zeros");
	// the code stands unchanged through acquisition until the next conversion
	AST_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_ACQ) |=> $stable(core.result))
		else $error("result changed outside a conversion");
	AST_VALID_DROP: assert property (@(posedge clock) disable iff (!rst_n)
		(core.phase == SCS_OPEN) |-> !result_valid)
		else $error("old result still flagged after a new start");
	// the arrays may only reach ground once the comparator side floats
	AST_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(core.to_ground) |-> (!$past(core.gnd_closed) && !core.gnd_closed))
		else $error("arrays grounded while ground switches closed");

	// readout-side checks
	AST_DRIVE_LOW: assert property (@(negedge host_shift_clock) disable iff (!link_rst_n)
		(link.edge_cnt == `SCS_LOAD_EDGE) |=> (serial_data_oe && !serial_data))
		else $error("fifth edge did not drive the line low");
	AST_QUIET: assert property (@(negedge host_shift_clock) disable iff (!link_rst_n)
		serial_data_oe |-> (link.edge_cnt > `SCS_LOAD_EDGE))
		else $error("line driven before the fifth edge");
	// each later edge puts out the bit that led the shift word
	AST_SHIFT_BIT: assert property (@(negedge host_shift_clock) disable iff (!link_rst_n)
		(link.oe && link.edge_cnt != `SCS_LAST_EDGE) |=>
		(serial_data == $past(link.shift[15])))
		else $error("serial bit is not the leading bit of the word");
	// the word is taken once, at the fifth edge, when a finished result stands
	AST_LOAD: assert property (@(negedge host_shift_clock) disable iff (!link_rst_n)
		(link.edge_cnt == `SCS_LOAD_EDGE && link.valid_sync) |=>
		(link.shift == $past(core.result)))
		else $error("readout did not take the finished result");
endmodule : scs_sequencer

// [verification/scs_host_model.sv]
// host model: drives select and shift clock, captures the serial result
// assumes the sequencer's serial pins; shift clock idles high outside frames
`timescale 1ns/1ps
module scs_host_model (
	// host pins
	output logic csn,
	output logic sclk,
	input wire logic sdo,
	input wire logic oe
);
	logic rel = 1'b1; // released line shows the inverse of the last driven bit
	wire line = oe ? sdo : rel;
	always @(negedge oe) rel = ~sdo;
	initial begin
		csn = 1'b1;
		sclk = 1'b1;
	end
	// one frame: select low starts the conversion, then 22 shift periods
	task automatic frame(output logic [15:0] w, output logic early, output logic [1:0] lead);
		w = 16'h0000;
		early = 1'b0;
		lead = 2'h0;
		csn = 1'b0;
		#3000; // wait out the conversion before edge five
		for (int i = 1; i <= 22; i++) begin
			#40 sclk = 1'b0;
			#40 sclk = 1'b1; // rising edge samples, data changes on the falling edge
			if (i == 4) early = oe;
			if (i == 5) lead = {oe, line};
			if (i >= 6 && i <= 21) w = {w[14:0], line};
		end
		csn = 1'b1; // sclk stands still from here
	endtask : frame
endmodule : scs_host_model

// [verification/scs_sequencer_tb_top.sv]
// testbench: random and boundary conversions, parallel and serial readback
// assumes the comparator follows the trial pattern against a held sample
`timescale 1ns/1ps
module scs_sequencer_tb_top;
	import scs_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0;
	logic [15:0] sample = 16'h0000, dac, code, w, tab[6];
	logic [1:0] mode = 2'h0, lead; // mode 0 normal, 1 overrange, 2 underrange
	logic csn, sclk, sdo, oe, valid, pwr, gp, gn, ai, ag, early;
	logic [15:0] expq[$]; // expected codes in request order
	int num_errors = 0, checks = 0;
	// ideal comparator: input at or above the trial level
	wire cmp = (mode == 2'h1) || (mode == 2'h0 && sample >= dac);
	initial forever #50 clock = ~clock;
	scs_host_model host (.csn(csn), .sclk(sclk), .sdo(sdo), .oe(oe));
	scs_sequencer dut (.clock(clock), .rst_n(rst_n), .chip_select_n(csn),
		.host_shift_clock(sclk), .serial_data(sdo), .serial_data_oe(oe),
		.comparator_high(cmp), .pos_array_ground_switch(gp), .neg_array_ground_switch(gn),
		.array_to_input(ai), .array_to_ground(ag), .dac_ref_select(dac),
		.converter_powered(pwr), .result_code(code), .result_valid(valid));
	task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_code
	task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp);
		chk_code({11'h000, got}, {11'h000, exp});
	endtask : chk_flag
	// watcher: each new result against the oldest note
	always @(posedge valid) begin
		#1;
		chk_code(code, expq.pop_front());
		chk_flag({pwr, ai, ag, gp, gn}, 5'h0b);
	end
	// one conversion plus serial readout
	task automatic conv(input logic [15:0] s, input logic [1:0] m);
		logic [15:0] e;
		@(negedge clock);
		sample = s;
		mode = m;
		e = (m == 2'h1) ? 16'hffff : (m == 2'h2) ? 16'h0000 : s;
		expq.push_back(e);
		fork
			host.frame(w, early, lead);
			begin
				repeat (8) @(negedge clock);
				chk_flag({pwr, ai, ag, gp, gn}, 5'h14);
				chk_code(dac, (e & 16'he000) | 16'h1000);
			end
		join
		chk_code(w, e);
		chk_flag({4'h0, early}, 5'h00);
		chk_flag({3'h0, lead}, 5'h02);
		@(negedge clock);
		chk_flag({4'h0, oe}, 5'h00);
		repeat (6) @(negedge clock);
		$display("conversion %h mode %0d done", s, m);
	endtask : conv
	task automatic final_report;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	initial begin
		#2000000;
		num_errors++;
		final_report();
	end
	initial begin
		tab = '{16'h8000, 16'h7fff, 16'h8001, 16'h0000, 16'hffff, 16'h0001};
		void'($urandom(32'hbad7889d));
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		repeat (8) @(negedge clock);
		foreach (tab[i]) conv(tab[i], 2'h0);
		conv(16'($urandom), 2'h1);
		conv(16'($urandom), 2'h2);
		repeat (6) conv(16'($urandom), 2'h0);
		chk_code(16'(expq.size()), 16'h0000);
		final_report();
	end
endmodule : scs_sequencer_tb_top
